// [design/ccr_consts.vh]
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH
// register map (index is the byte address on the plain port)
`define CCR_ADDR_W        4
`define CCR_ADDR_RANGE    4'h4
`define CCR_ADDR_CLAMP    4'h7
`define CCR_ADDR_STATUS   4'h8
`define CCR_DATA_W        16
`define CCR_RESET_VAL     16'h0000
// clamp register field positions
`define CCR_RSV_HI        15
`define CCR_RSV_LO        12
`define CCR_SEL_HI        11
`define CCR_SEL_LO        10
`define CCR_POS_HI        9
`define CCR_POS_LO        6
`define CCR_NEG_HI        5
`define CCR_NEG_LO        2
// clamp select codes
`define CCR_SEL_TRACK     2'h0
`define CCR_SEL_USER      2'h1
`define CCR_SEL_AUTO      2'h2
`define CCR_SEL_BAD       2'h3
// status word bit positions
`define CCR_ST_TRACK      0
`define CCR_ST_USER       1
`define CCR_ST_AUTO       2
`define CCR_ST_VMODE      3
`define CCR_ST_POSOK      4
`define CCR_ST_BADSEL     5
// positive clamp codes valid in voltage output mode
`define CCR_POS_V9        4'h3
`define CCR_POS_V15       4'h8
`define CCR_POS_V18       4'h9
`endif

// [design/ccr_sync3.v]
`timescale 1ns/1ps
// three-stage input synchroniser; output moves only when stages 2 and 3 agree
module ccr_sync3 #(
   parameter W = 4
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire         ce,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;

   // first stage feeds only the second; agreement filters one-edge glitches
   always @(posedge clk) begin
      if (!rst_n) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
         s3_reg <= {W{1'b0}};
         q      <= {W{1'b0}};
      end else if (ce) begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q <= s3_reg;
         end
      end
   end
endmodule

// [design/ccr_tune.v]
`timescale 1ns/1ps
`include "ccr_consts.vh"
// picks the optimum positive clamp code from the sensed headroom code.
// in voltage mode it snaps up to the next legal code (9, 15 or 18 V), capping at 18 V
module ccr_tune (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       ce,
   input  wire       enable,
   input  wire       volt_mode,
   input  wire [3:0] sense_code,
   output reg  [3:0] best_code,
   output reg        best_valid
);
   reg [3:0] snap;

   // snap to legal voltage-mode codes; current mode takes any code
   always @* begin
      snap = sense_code;
      if (volt_mode) begin
         if (sense_code <= `CCR_POS_V9) begin
            snap = `CCR_POS_V9;
         end else if (sense_code <= `CCR_POS_V15) begin
            snap = `CCR_POS_V15;
         end else begin
            snap = `CCR_POS_V18;
         end
      end
   end

   // valid held high, with a fresh code every cycle, while tuning is on
   always @(posedge clk) begin
      if (!rst_n) begin
         best_code  <= 4'h0;
         best_valid <= 1'b0;
      end else if (ce) begin
         best_valid <= enable;
         if (enable) begin
            best_code <= snap;
         end
      end
   end
endmodule

// [design/ccr_clamp_regs.v]
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "ccr_consts.vh"
module ccr_clamp_regs (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        ce,
   input  wire [3:0]  addr,
   input  wire [15:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [15:0] rdata,
   input  wire [3:0]  headroom_code,
   output wire        track_mode,
   output wire        user_mode,
   output wire        auto_mode,
   output wire        volt_mode,
   output reg  [3:0]  pos_clamp,
   output reg  [3:0]  neg_clamp,
   output wire        pos_clamp_ok
);
   reg  [3:0] rsv_reg;
   reg  [1:0] sel_reg;
   reg  [3:0] pos_reg;
   reg  [3:0] neg_reg;
   reg  [3:0] range_reg;
   reg        bad_sel_reg;
   reg  [1:0] sel_next;
   reg  [3:0] pos_next;
   reg  [3:0] neg_next;
   wire [3:0] head_sync;
   wire [3:0] tune_code;
   wire       tune_valid;
   wire       wr_clamp;
   wire [15:0] clamp_word;
   wire [15:0] status_word;
   reg  [15:0] rdata_next;
   reg  [3:0] pos_clamp_next;
   reg  [3:0] neg_clamp_next;
   wire       wr_range;
   wire       rd_clamp;
   wire       rd_range;
   wire       rd_status;
   wire [3:0] wr_rsv;
   wire [1:0] wr_sel;
   wire [3:0] wr_pos;
   wire [3:0] wr_neg;
   wire       sel_is_bad;
   wire       clamps_off;

   // range codes 0xxx below 4 and 10xx are voltage ranges
   function is_volt_range;
      input [3:0] r;
      begin
         is_volt_range = (r[3:2] == 2'b00) || (r[3:2] == 2'b10);
      end
   endfunction

   // positive clamp code legal for the output mode in force
   function pos_legal;
      input [3:0] c;
      input       v;
      begin
         pos_legal = !v || (c == `CCR_POS_V9) || (c == `CCR_POS_V15)
                     || (c == `CCR_POS_V18);
      end
   endfunction

   // true when a strobe on the plain port hits the given register index
   function hits;
      input       strobe;
      input [3:0] a;
      input [3:0] target;
      begin
         hits = strobe && (a == target);
      end
   endfunction

   // select field of a clamp register word
   function [1:0] sel_of;
      input [15:0] w;
      begin
         sel_of = w[`CCR_SEL_HI:`CCR_SEL_LO];
      end
   endfunction

   // positive clamp field of a clamp register word
   function [3:0] pos_of;
      input [15:0] w;
      begin
         pos_of = w[`CCR_POS_HI:`CCR_POS_LO];
      end
   endfunction

   // negative clamp field of a clamp register word
   function [3:0] neg_of;
      input [15:0] w;
      begin
         neg_of = w[`CCR_NEG_HI:`CCR_NEG_LO];
      end
   endfunction

   // reserved nibble of a clamp register word
   function [3:0] rsv_of;
      input [15:0] w;
      begin
         rsv_of = w[`CCR_RSV_HI:`CCR_RSV_LO];
      end
   endfunction

   // builds the clamp register word; bits 1:0 always read zero
   function [15:0] pack_clamp;
      input [3:0] r;
      input [1:0] s;
      input [3:0] p;
      input [3:0] n;
      begin
         pack_clamp = {r, s, p, n, 2'b00};
      end
   endfunction

   // builds the status word from the live mode flags
   function [15:0] pack_status;
      input bad;
      input ok;
      input v;
      input a;
      input u;
      input t;
      begin
         pack_status = {10'h000, bad, ok, v, a, u, t};
      end
   endfunction

   // strobe decode; unmapped indices fall through and do nothing
   assign wr_clamp    = hits(wr, addr, `CCR_ADDR_CLAMP);
   assign wr_range    = hits(wr, addr, `CCR_ADDR_RANGE);
   assign rd_clamp    = hits(rd, addr, `CCR_ADDR_CLAMP);
   assign rd_range    = hits(rd, addr, `CCR_ADDR_RANGE);
   assign rd_status   = hits(rd, addr, `CCR_ADDR_STATUS);

   // write data split into the clamp register fields
   assign wr_rsv      = rsv_of(wdata);
   assign wr_sel      = sel_of(wdata);
   assign wr_pos      = pos_of(wdata);
   assign wr_neg      = neg_of(wdata);
   assign sel_is_bad  = (wr_sel == `CCR_SEL_BAD);

   // decoded mode flags
   assign volt_mode   = is_volt_range(range_reg);
   assign track_mode  = (sel_reg == `CCR_SEL_TRACK);
   assign user_mode   = (sel_reg == `CCR_SEL_USER);
   assign auto_mode   = (sel_reg == `CCR_SEL_AUTO);
   assign pos_clamp_ok = pos_legal(pos_reg, volt_mode);

   // headroom code arrives from the analog side, so it is resynchronised
   ccr_sync3 #(
      .W (4)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .d     (headroom_code),
      .q     (head_sync)
   );

   ccr_tune u_tune (
      .clk        (clk),
      .rst_n      (rst_n),
      .ce         (ce),
      .enable     (auto_mode),
      .volt_mode  (volt_mode),
      .sense_code (head_sync),
      .best_code  (tune_code),
      .best_valid (tune_valid)
   );

   // next-state for the clamp fields
   always @* begin
      sel_next = sel_reg;
      pos_next = pos_reg;
      neg_next = neg_reg;
      if (wr_clamp) begin
         // select 11 is kept as written; software is not to use it
         sel_next = wr_sel;
         // clamp writes count only while user mode is already in force
         if (user_mode) begin
            pos_next = wr_pos;
            neg_next = wr_neg;
         end
      end
      // in self-tune mode only hardware writes the positive clamp
      if (auto_mode && tune_valid) begin
         pos_next = tune_code;
      end
   end

   // select field register; all state is frozen while ce is low
   always @(posedge clk) begin
      if (!rst_n) begin
         sel_reg <= `CCR_SEL_TRACK;
      end else if (ce) begin
         sel_reg <= sel_next;
      end
   end

   // positive clamp field; hardware or software, never both in one mode
   always @(posedge clk) begin
      if (!rst_n) begin
         pos_reg <= 4'h0;
      end else if (ce) begin
         pos_reg <= pos_next;
      end
   end

   // negative clamp field
   always @(posedge clk) begin
      if (!rst_n) begin
         neg_reg <= 4'h0;
      end else if (ce) begin
         neg_reg <= neg_next;
      end
   end

   // reserved nibble: stored and read back, drives nothing else
   always @(posedge clk) begin
      if (!rst_n) begin
         rsv_reg <= 4'h0;
      end else if (ce && wr_clamp) begin
         rsv_reg <= wr_rsv;
      end
   end

   // stand-in for the output range field; only its mode bit matters here
   always @(posedge clk) begin
      if (!rst_n) begin
         range_reg <= 4'h0;
      end else if (ce && wr_range) begin
         range_reg <= wdata[3:0];
      end
   end

   // sticky flag for a forbidden select; only reset clears it, so a
   // stray write stays visible to software long after it happened
   always @(posedge clk) begin
      if (!rst_n) begin
         bad_sel_reg <= 1'b0;
      end else if (ce && wr_clamp && sel_is_bad) begin
         bad_sel_reg <= 1'b1;
      end
   end

   // clamp levels follow the fields at the same edge; the next select is
   // used so no stale level is left for a cycle after a mode change
   assign clamps_off = (sel_next == `CCR_SEL_TRACK);

   // tracking mode hands the supply its defaults instead of the fields
   always @* begin
      pos_clamp_next = pos_next;
      neg_clamp_next = neg_next;
      if (clamps_off) begin
         pos_clamp_next = 4'h0;
         neg_clamp_next = 4'h0;
      end
   end

   // clamp output registers; data outputs come straight from flip-flops
   always @(posedge clk) begin
      if (!rst_n) begin
         pos_clamp <= 4'h0;
         neg_clamp <= 4'h0;
      end else if (ce) begin
         pos_clamp <= pos_clamp_next;
         neg_clamp <= neg_clamp_next;
      end
   end

   assign clamp_word  = pack_clamp(rsv_reg, sel_reg, pos_reg, neg_reg);
   assign status_word = pack_status(bad_sel_reg, pos_clamp_ok, volt_mode,
                                    auto_mode, user_mode, track_mode);

   // read mux; unmapped indices and idle cycles return zero
   always @* begin
      rdata_next = 16'h0000;
      if (rd_clamp) begin
         rdata_next = clamp_word;
      end else if (rd_range) begin
         rdata_next = {12'h000, range_reg};
      end else if (rd_status) begin
         rdata_next = status_word;
      end
   end

   // read data stand in the cycle after the read strobe only; zero
   // otherwise so a stale word is never mistaken for a fresh answer
   always @(posedge clk) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
      end else if (ce) begin
         rdata <= rdata_next;
      end
   end
endmodule

// [verif/ccr_clamp_properties.sv]
`timescale 1ns/1ps
// port-level checks on the clamp register bank
module ccr_clamp_properties (
   input logic        clk,
   input logic        rst_n,
   input logic        ce,
   input logic [3:0]  addr,
   input logic [15:0] wdata,
   input logic        wr,
   input logic        rd,
   input logic [15:0] rdata,
   input logic        track_mode,
   input logic        user_mode,
   input logic        auto_mode,
   input logic        volt_mode,
   input logic [3:0]  pos_clamp,
   input logic [3:0]  neg_clamp
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_reset_state: assert property ($rose(rst_n) |-> track_mode
      && pos_clamp == 4'h0 && neg_clamp == 4'h0) else $error("reset state");
   a_track_clamps: assert property (track_mode |-> !user_mode
      && !auto_mode && pos_clamp == 4'h0 && neg_clamp == 4'h0)
      else $error("tracking clamps");
   a_rdata_idle: assert property (ce && !rd |=> rdata == 16'h0000)
      else $error("rdata idle");
   a_unmapped_zero: assert property (ce && rd && addr != 4'h4
      && addr != 4'h7 && addr != 4'h8 |=> rdata == 16'h0000)
      else $error("unmapped read");
   a_user_write: assert property (user_mode && ce && wr
      && addr == 4'h7 && wdata[11:10] == 2'h1
      |=> pos_clamp == $past(wdata[9:6]) && neg_clamp == $past(wdata[5:2]))
      else $error("user write");
   a_auto_neg_hold: assert property (auto_mode && ce && wr
      && addr == 4'h7 && wdata[11:10] == 2'h2
      |=> auto_mode && neg_clamp == $past(neg_clamp))
      else $error("auto neg hold");
   a_sel_readback: assert property (ce && rd && addr == 4'h7
      && (user_mode || auto_mode) |=> rdata[1:0] == 2'h0
      && rdata[11:10] == $past({auto_mode, user_mode}))
      else $error("select readback");
   a_range_mode: assert property (ce && rd && addr == 4'h4
      |=> volt_mode == !rdata[2]) else $error("range mode");
endmodule
bind ccr_clamp_regs ccr_clamp_properties u_props (.*);

// [verif/test_converter_clamp_config_register.sv]
`timescale 1ns/1ps
module test_converter_clamp_config_register;
   logic        clk, rst_n, ce, wr, rd;
   logic [3:0]  addr, hr;
   logic [15:0] wdata;
   wire  [15:0] rdata;
   wire  [3:0]  pos, neg;
   wire         trk, usr, aut, vm, ok;
   int          error_cnt = 0;
   int          compares = 0;
   ccr_clamp_regs u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .headroom_code(hr),
      .track_mode(trk), .user_mode(usr), .auto_mode(aut), .volt_mode(vm),
      .pos_clamp(pos), .neg_clamp(neg), .pos_clamp_ok(ok));
   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one-cycle write strobe on the plain port
   task automatic wr_reg(logic [3:0] a, logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe, so look there
   task automatic rd_chk(string n, logic [3:0] a, logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(n, e, rdata);
   endtask
   // tuning passes a synchroniser first, so poll under a bound
   task automatic wait_pos(logic [3:0] e);
      for (int i = 0; i < 40 && pos !== e; i++) begin
         @(posedge clk);
         #1;
      end
      chk("pos_clamp", {12'h000, e}, {12'h000, pos});
      if (pos !== e)
         report_and_stop();
   endtask
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      hr = 4'hB;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("clamp", 4'h7, 16'h0000);
      rd_chk("unmapped", 4'hF, 16'h0000);
      chk("track", 16'h0001, {15'h0000, trk});
      $display("test reset done");
      // clamps in the same write as select 01 are not taken
      wr_reg(4'h7, 16'hF67C);
      rd_chk("clamp", 4'h7, 16'hF400);
      chk("user", 16'h0001, {15'h0000, usr});
      wr_reg(4'h7, 16'hF65C);
      rd_chk("clamp", 4'h7, 16'hF65C);
      chk("neg", 16'h0007, {12'h000, neg});
      wr_reg(4'h7, 16'h0000);
      #1 chk("pos", 16'h0000, {12'h000, pos});
      chk("neg", 16'h0000, {12'h000, neg});
      $display("test user done");
      wr_reg(4'h4, 16'h0004);
      #1 chk("volt", 16'h0000, {15'h0000, vm});
      wr_reg(4'h7, 16'h0400);
      wr_reg(4'h7, 16'h0800);
      wait_pos(4'hB);
      chk("auto", 16'h0001, {15'h0000, aut});
      wr_reg(4'h7, 16'h0880);
      rd_chk("clamp", 4'h7, 16'h0AC0);
      wr_reg(4'h4, 16'h0009);
      #1 chk("volt", 16'h0001, {15'h0000, vm});
      wait_pos(4'h9);
      chk("pos_ok", 16'h0001, {15'h0000, ok});
      rd_chk("status", 4'h8, 16'h001C);
      @(posedge clk);
      hr <= 4'h2;
      wait_pos(4'h3);
      rd_chk("range", 4'h4, 16'h0009);
      $display("test auto done");
      // a write while ce is low must leave every field alone
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(4'h7, 16'h0400);
      ce <= 1'b1;
      rd_chk("frozen", 4'h7, 16'h08C0);
      $display("test enable done");
      // second reset in mid-run clears every field again
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("clamp", 4'h7, 16'h0000);
      rd_chk("range", 4'h4, 16'h0000);
      chk("track", 16'h0001, {15'h0000, trk});
      $display("test reset again done");
      report_and_stop();
   end
endmodule
